/* rtl/ebtwu_map.vh */
// Register map, field positions, reset values and timing constants of the timer.
// Assumes inclusion by the timer top module and its testbench; definitions only.
`ifndef EBTWU_MAP_VH
`define EBTWU_MAP_VH

`define EBTWU_OFF_CONTROL     12'h000
`define EBTWU_OFF_COUNT       12'h004
`define EBTWU_OFF_COMPARE     12'h008
`define EBTWU_OFF_FLAGS       12'h00c
`define EBTWU_OFF_PORT        12'h010
`define EBTWU_OFF_SERVICE     12'h014

`define EBTWU_BIT_FORCE       7
`define EBTWU_BIT_WGM_LO      6
`define EBTWU_BIT_COM_HI      5
`define EBTWU_BIT_COM_LO      4
`define EBTWU_BIT_WGM_HI      3
`define EBTWU_BIT_CS_HI       2

`define EBTWU_BIT_FLAG_MATCH  0
`define EBTWU_BIT_FLAG_OVF    1
`define EBTWU_BIT_PORT_DIR    0
`define EBTWU_BIT_PORT_DATA   1

`define EBTWU_RST_CONTROL     8'h00
`define EBTWU_RST_COUNT       8'h00
`define EBTWU_RST_COMPARE     8'h00

`define EBTWU_MODE_NORMAL     2'h0
`define EBTWU_MODE_PCPWM      2'h1
`define EBTWU_MODE_CTC        2'h2
`define EBTWU_MODE_FPWM       2'h3

`define EBTWU_MAX             8'hff
`define EBTWU_BOTTOM          8'h00

`define EBTWU_DIV8_LAST       10'h007
`define EBTWU_DIV64_LAST      10'h03f
`define EBTWU_DIV256_LAST     10'h0ff
`define EBTWU_DIV1024_LAST    10'h3ff

`endif

/* rtl/ebtwu_timer.v */
// Eight-bit timer/counter with waveform unit and an APB register slave.
// Assumes one clock, synchronous active-high reset, APB master on the same clock.
//
// How it works
// - All logic runs on sys_clk; the timer tick is a one-cycle enable.
// - Force-compare acts only in normal or clear-on-match mode.
// - Force-compare updates the output pin at once using the output mode written with it.
// - Forced compare sets no flag and never clears the counter.
// - Force-compare bit always reads as zero.
// - Control bits 6 and 3 select normal, phase PWM, clear-on-match, fast PWM.
// - TOP is 0xff or compare; buffered compare in PWM; overflow at MAX/BOTTOM.
// - Nonzero output mode overrides port; driver enabled only by direction bit.
// - Non-PWM output mode: off, toggle, clear, set on match.
// - Fast PWM output mode: off, reserved, clear/set at TOP, set/clear at TOP.
// - Phase PWM: clear up-match set down-match, or the inverse.
// - PWM with compare at TOP and upper mode bit: match ignored, TOP acts.
// - Clock select 0 stops, 1 direct, 2..5 divide by 8, 64, 256, 1024.
// - Clock select 6 counts falling, 7 rising edges of the count pin.
// - Count pin edges clock the counter even when the pin drives out.
// - Counter register is readable and writable by software.
// - A counter write blocks the compare match on the next tick.
// - Match flag sets on match; cleared by service ack or writing one.
// - Overflow flag sets on overflow; cleared by service ack or writing one.
// - Count pin sampled every clock and edge detected; 2 to 3 clocks.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps

module ebtwu_timer (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        count_pin_in,
  output reg         compare_output_pin,
  output reg         compare_output_pin_oe_n,
  output reg         compare_match_flag,
  output reg         overflow_flag
);

`include "ebtwu_map.vh"

  reg  [7:0] timer_control;
  reg  [7:0] timer_count_value;
  reg  [7:0] compare_value;
  reg  [7:0] compare_buffer;
  reg        port_dir;
  reg        port_data;
  reg        wave;
  reg        count_down;
  reg        block_match;
  reg  [9:0] prescale;
  reg        pin_sync;
  reg        pin_sample;
  reg        pin_prev;

  wire [1:0] waveform_mode_bits;
  wire [1:0] compare_output_mode;
  wire [2:0] clock_select_bits;
  wire       is_pwm;
  wire       access;
  wire       wr;
  wire       wr_control;
  wire       wr_count;
  wire       wr_compare;
  wire       wr_flags;
  wire       wr_port;
  wire       wr_service;
  wire       force_now;
  wire [7:0] top_value;
  wire       at_top;
  wire       raw_match;
  wire       match;
  wire       ovf_event;
  wire       tick;
  wire       pin_rise;
  wire       pin_fall;
  wire       setup;
  wire       clr_match;
  wire       clr_ovf;
  wire       top_only;
  reg        next_wave;
  reg  [7:0] next_count;
  reg        next_down;

  // Bit 3 is the high mode bit, bit 6 the low one
  assign waveform_mode_bits  = {timer_control[`EBTWU_BIT_WGM_HI],
                                timer_control[`EBTWU_BIT_WGM_LO]};
  assign compare_output_mode = timer_control[`EBTWU_BIT_COM_HI:`EBTWU_BIT_COM_LO];
  assign clock_select_bits   = timer_control[`EBTWU_BIT_CS_HI:0];
  assign is_pwm              = waveform_mode_bits[0];

  // Full-address compare, so byte aliases of a register are refused
  function addr_hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      addr_hit = (addr == off);
    end
  endfunction

  assign access     = psel && penable;
  assign setup      = psel && !penable;
  assign wr         = access && pwrite;
  assign wr_control = wr && addr_hit(paddr, `EBTWU_OFF_CONTROL);
  assign wr_count   = wr && addr_hit(paddr, `EBTWU_OFF_COUNT);
  assign wr_compare = wr && addr_hit(paddr, `EBTWU_OFF_COMPARE);
  assign wr_flags   = wr && addr_hit(paddr, `EBTWU_OFF_FLAGS);
  assign wr_port    = wr && addr_hit(paddr, `EBTWU_OFF_PORT);
  assign wr_service = wr && addr_hit(paddr, `EBTWU_OFF_SERVICE);

  // Service write stands in for the hardware clear on vector entry
  assign clr_match  = (wr_flags || wr_service) && pwdata[`EBTWU_BIT_FLAG_MATCH];
  assign clr_ovf    = (wr_flags || wr_service) && pwdata[`EBTWU_BIT_FLAG_OVF];

  // Strobe never stored; only acts in non-PWM modes
  assign force_now = wr_control && pwdata[`EBTWU_BIT_FORCE]
                     && !pwdata[`EBTWU_BIT_WGM_LO];

  // Prescaler free-runs, so the first prescaled tick may come early
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      prescale <= 10'h000;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  // Pin sampled every clock, then edge detected; the pin's direction is ignored
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_sync   <= 1'b0;
      pin_sample <= 1'b0;
      pin_prev   <= 1'b0;
    end else begin
      pin_sync   <= count_pin_in;
      pin_sample <= pin_sync;
      pin_prev   <= pin_sample;
    end
  end

  assign pin_rise = pin_sample && !pin_prev;
  assign pin_fall = !pin_sample && pin_prev;

  function tick_sel;
    input [2:0] cs;
    input [9:0] pre;
    input       rise;
    input       fall;
    begin
      case (cs)
        3'h0: tick_sel = 1'b0;
        3'h1: tick_sel = 1'b1;
        3'h2: tick_sel = ((pre & `EBTWU_DIV8_LAST) == `EBTWU_DIV8_LAST);
        3'h3: tick_sel = ((pre & `EBTWU_DIV64_LAST) == `EBTWU_DIV64_LAST);
        3'h4: tick_sel = ((pre & `EBTWU_DIV256_LAST) == `EBTWU_DIV256_LAST);
        3'h5: tick_sel = (pre == `EBTWU_DIV1024_LAST);
        3'h6: tick_sel = fall;
        default: tick_sel = rise;
      endcase
    end
  endfunction

  assign tick = tick_sel(clock_select_bits, prescale, pin_rise, pin_fall);

  // TOP is the compare value only in clear-on-match mode
  assign top_value = (waveform_mode_bits == `EBTWU_MODE_CTC) ? compare_value
                                                             : `EBTWU_MAX;
  assign at_top    = (timer_count_value == top_value);
  assign raw_match = (timer_count_value == compare_buffer) && !block_match;
  // In PWM a compare value equal to TOP with the upper mode bit set is ignored
  assign top_only  = is_pwm && compare_output_mode[1] && (compare_buffer == `EBTWU_MAX);
  assign match     = raw_match && !top_only;
  assign ovf_event = tick && ((waveform_mode_bits == `EBTWU_MODE_PCPWM)
                     ? (count_down && timer_count_value == 8'h01)
                     : (timer_count_value == `EBTWU_MAX));

  always @* begin
    next_count = timer_count_value;
    next_down  = count_down;
    case (waveform_mode_bits)
      `EBTWU_MODE_PCPWM: begin
        if (!count_down) begin
          if (timer_count_value == `EBTWU_MAX) begin
            next_down  = 1'b1;
            next_count = timer_count_value - 8'h01;
          end else begin
            next_count = timer_count_value + 8'h01;
          end
        end else begin
          if (timer_count_value == `EBTWU_BOTTOM) begin
            next_down  = 1'b0;
            next_count = timer_count_value + 8'h01;
          end else begin
            next_count = timer_count_value - 8'h01;
          end
        end
      end
      `EBTWU_MODE_CTC: begin
        next_down  = 1'b0;
        next_count = at_top ? `EBTWU_BOTTOM : timer_count_value + 8'h01;
      end
      default: begin
        next_down  = 1'b0;
        next_count = timer_count_value + 8'h01;
      end
    endcase
  end

  // Output action on a match in non-PWM modes, shared with the forced compare
  function com_action;
    input [1:0] mode;
    input       cur;
    begin
      case (mode)
        2'h1:    com_action = !cur;
        2'h2:    com_action = 1'b0;
        2'h3:    com_action = 1'b1;
        default: com_action = cur;
      endcase
    end
  endfunction

  always @* begin
    next_wave = wave;
    if (force_now) begin
      // Forced compare uses the output mode being written at the same time
      next_wave = com_action(pwdata[`EBTWU_BIT_COM_HI:`EBTWU_BIT_COM_LO], wave);
    end else if (tick) begin
      case (waveform_mode_bits)
        `EBTWU_MODE_FPWM: begin
          if (compare_output_mode[1] && at_top) begin
            next_wave = !compare_output_mode[0];
          end else if (compare_output_mode[1] && match) begin
            next_wave = compare_output_mode[0];
          end
        end
        `EBTWU_MODE_PCPWM: begin
          if (compare_output_mode[1] && match) begin
            next_wave = compare_output_mode[0] ^ count_down;
          end else if (top_only && timer_count_value == `EBTWU_MAX) begin
            next_wave = !compare_output_mode[0];
          end
        end
        default: begin
          if (match) begin
            next_wave = com_action(compare_output_mode, wave);
          end
        end
      endcase
    end
  end

  // Software-written registers; the strobe bit is never stored
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_control <= `EBTWU_RST_CONTROL;
      compare_value <= `EBTWU_RST_COMPARE;
      port_dir      <= 1'b0;
      port_data     <= 1'b0;
    end else begin
      if (wr_control) begin
        timer_control <= {1'b0, pwdata[6:0]};
      end
      if (wr_compare) begin
        compare_value <= pwdata[7:0];
      end
      if (wr_port) begin
        port_dir  <= pwdata[`EBTWU_BIT_PORT_DIR];
        port_data <= pwdata[`EBTWU_BIT_PORT_DATA];
      end
    end
  end

  // Non-PWM modes load at once; PWM waits for TOP to avoid glitched duty
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      compare_buffer <= `EBTWU_RST_COMPARE;
    end else if (!is_pwm || (tick && at_top)) begin
      compare_buffer <= wr_compare ? pwdata[7:0] : compare_value;
    end
  end

  // Software write beats the tick on the same edge
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_count_value <= `EBTWU_RST_COUNT;
      count_down        <= 1'b0;
      block_match       <= 1'b0;
    end else if (wr_count) begin
      timer_count_value <= pwdata[7:0];
      block_match       <= 1'b1;
    end else if (tick) begin
      timer_count_value <= next_count;
      count_down        <= next_down;
      block_match       <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end

  // Set wins over clear; forced compare never sets the flag
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      compare_match_flag <= 1'b0;
      overflow_flag      <= 1'b0;
    end else begin
      if (tick && raw_match) begin
        compare_match_flag <= 1'b1;
      end else if (clr_match) begin
        compare_match_flag <= 1'b0;
      end
      if (ovf_event) begin
        overflow_flag <= 1'b1;
      end else if (clr_ovf) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // Pin level and driver enable registered so outputs come from flip-flops
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      compare_output_pin      <= 1'b0;
      compare_output_pin_oe_n <= 1'b1;
    end else begin
      compare_output_pin      <= (compare_output_mode != 2'h0) ? wave
                                                               : port_data;
      compare_output_pin_oe_n <= !port_dir;
    end
  end

  // Zero-wait slave: pready rises in the first access cycle
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (setup) begin
        case (paddr)
          `EBTWU_OFF_CONTROL: prdata <= {24'h000000, 1'b0, timer_control[6:0]};
          `EBTWU_OFF_COUNT:   prdata <= {24'h000000, timer_count_value};
          `EBTWU_OFF_COMPARE: prdata <= {24'h000000, compare_value};
          `EBTWU_OFF_FLAGS:   prdata <= {30'h00000000, overflow_flag, compare_match_flag};
          `EBTWU_OFF_PORT:    prdata <= {30'h00000000, port_data, port_dir};
          `EBTWU_OFF_SERVICE: prdata <= 32'h00000000;
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // ebtwu_timer

/* bench/ebtwu_timer_checker.sv */
// Checker: bus answer timing, read data and cause of driver-enable changes and flag clears.
// Assumes it is bound onto ebtwu_timer and sees that module's ports only.
`timescale 1ns/1ps

module ebtwu_timer_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        count_pin_in,
  input wire logic        compare_output_pin,
  input wire logic        compare_output_pin_oe_n,
  input wire logic        compare_match_flag,
  input wire logic        overflow_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  wire acc     = psel && penable && pready;
  wire wr_flag = acc && pwrite && (paddr == 12'h00c || paddr == 12'h014);
  wire wr_port = acc && pwrite && paddr == 12'h010;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence

  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("no answer in the cycle after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside an answer");
  a_unmapped_err: assert property (acc && paddr > 12'h014 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_force_zero: assert property (acc && !pwrite && paddr == 12'h000 |-> !prdata[7])
    else $error("force bit read as one");
  a_match_clear: assert property ($fell(compare_match_flag) |-> $past(wr_flag) || $past(wr_flag, 2))
    else $error("match flag fell without a clearing write");
  a_ovf_clear: assert property ($fell(overflow_flag) |-> $past(wr_flag) || $past(wr_flag, 2))
    else $error("overflow flag fell without a clearing write");
  a_oe_cause: assert property ($changed(compare_output_pin_oe_n) |-> $past(wr_port) || $past(wr_port, 2))
    else $error("driver enable changed without a port write");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !compare_match_flag && !overflow_flag && compare_output_pin_oe_n && !pready)
    else $error("outputs not at rest after reset");
endmodule // ebtwu_timer_checker

bind ebtwu_timer ebtwu_timer_checker i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .count_pin_in(count_pin_in),
  .compare_output_pin(compare_output_pin), .compare_output_pin_oe_n(compare_output_pin_oe_n),
  .compare_match_flag(compare_match_flag), .overflow_flag(overflow_flag));

/* bench/ebtwu_timer_tb_top.sv */
// Testbench: drives the timer over the register bus and its count pin.
// Assumes ebtwu_timer and ebtwu_map.vh on the include path; reads checked via a queue.
`timescale 1ns/1ps
`include "ebtwu_map.vh"

module ebtwu_timer_tb_top;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        count_pin_in = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        oe_n;
  logic        mflag;
  logic        oflag;
  logic [31:0] exp_q[$];
  int          error_cnt = 0;
  int          compares = 0;
  int          i;
  int          div[5] = '{1, 8, 64, 256, 1024};
  logic [7:0]  v;

  always #20 sys_clk = ~sys_clk;

  ebtwu_timer i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin_in(count_pin_in), .compare_output_pin(pin),
    .compare_output_pin_oe_n(oe_n), .compare_match_flag(mflag), .overflow_flag(oflag));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic summarize;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Idle edge at the end keeps psel from being assigned twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n >= 16) begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    xfer(1'b0, a, 8'h00);
  endtask

  // Both writes take the same cycles, so the count sees exactly w clocks
  task automatic run(input logic [7:0] ctrl, input int w);
    wr(`EBTWU_OFF_CONTROL, ctrl);
    repeat (w - 3) @(posedge sys_clk);
    wr(`EBTWU_OFF_CONTROL, 8'h00);
  endtask

  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() != 0) begin
      chk("read data", prdata, exp_q.pop_front());
    end
  end

  initial begin
    void'($urandom(32'h803a4351));
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(`EBTWU_OFF_CONTROL, 8'h00);
    rd(`EBTWU_OFF_COUNT, 8'h00);
    rd(`EBTWU_OFF_FLAGS, 8'h00);
    rd(12'h018, 8'h00);
    v = 8'($urandom);
    wr(`EBTWU_OFF_COMPARE, v);
    rd(`EBTWU_OFF_COMPARE, v);
    wr(`EBTWU_OFF_PORT, 8'h01);
    wr(`EBTWU_OFF_COUNT, 8'h33);
    for (i = 0; i < 4; i++) begin
      wr(`EBTWU_OFF_CONTROL, 8'h80 | (i[0] ? 8'h08 : 8'h00) | 8'((i % 3 + 1) << 4));
      @(posedge sys_clk);
      chk("compare pin", pin, !i[0]);
    end
    chk("driver enable", oe_n, 1'b0);
    rd(`EBTWU_OFF_COUNT, 8'h33);
    rd(`EBTWU_OFF_FLAGS, 8'h00);
    wr(`EBTWU_OFF_CONTROL, 8'h78);
    wr(`EBTWU_OFF_CONTROL, 8'hf8);
    @(posedge sys_clk);
    chk("pwm force", pin, 1'b0);
    wr(`EBTWU_OFF_PORT, 8'h03);
    wr(`EBTWU_OFF_CONTROL, 8'h00);
    @(posedge sys_clk);
    chk("port data", pin, 1'b1);
    wr(`EBTWU_OFF_PORT, 8'h00);
    @(posedge sys_clk);
    chk("driver off", oe_n, 1'b1);
    v = (8'($urandom) & 8'h78) | 8'h80;
    wr(`EBTWU_OFF_CONTROL, v);
    rd(`EBTWU_OFF_CONTROL, v & 8'h7f);
    for (i = 0; i < 5; i++) begin
      wr(`EBTWU_OFF_COUNT, 8'h00);
      run(8'(i + 1), 8 * div[i]);
      rd(`EBTWU_OFF_COUNT, 8'h08);
    end
    wr(`EBTWU_OFF_PORT, 8'h01);
    for (i = 6; i < 8; i++) begin
      wr(`EBTWU_OFF_COUNT, 8'h00);
      wr(`EBTWU_OFF_CONTROL, 8'(i));
      repeat (5) begin
        count_pin_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        count_pin_in <= 1'b0;
        repeat (3) @(posedge sys_clk);
      end
      repeat (4) @(posedge sys_clk);
      wr(`EBTWU_OFF_CONTROL, 8'h00);
      rd(`EBTWU_OFF_COUNT, 8'h05);
    end
    wr(`EBTWU_OFF_COMPARE, 8'h10);
    wr(`EBTWU_OFF_FLAGS, 8'h03);
    wr(`EBTWU_OFF_COUNT, 8'h10);
    run(8'h01, 6);
    rd(`EBTWU_OFF_FLAGS, 8'h00);
    wr(`EBTWU_OFF_COUNT, 8'h0e);
    run(8'h01, 6);
    rd(`EBTWU_OFF_FLAGS, 8'h01);
    chk("match flag pin", mflag, 1'b1);
    wr(`EBTWU_OFF_SERVICE, 8'h01);
    rd(`EBTWU_OFF_FLAGS, 8'h00);
    wr(`EBTWU_OFF_COUNT, 8'hfc);
    run(8'h01, 8);
    rd(`EBTWU_OFF_FLAGS, 8'h02);
    rd(`EBTWU_OFF_COUNT, 8'h04);
    wr(`EBTWU_OFF_FLAGS, 8'h02);
    rd(`EBTWU_OFF_FLAGS, 8'h00);
    wr(`EBTWU_OFF_COMPARE, 8'h05);
    wr(`EBTWU_OFF_COUNT, 8'h00);
    run(8'h09, 20);
    rd(`EBTWU_OFF_COUNT, 8'h02);
    wr(`EBTWU_OFF_COMPARE, 8'h04);
    wr(`EBTWU_OFF_COUNT, 8'hfd);
    wr(`EBTWU_OFF_CONTROL, 8'h69);
    wr(`EBTWU_OFF_CONTROL, 8'h68);
    @(posedge sys_clk);
    chk("fast pwm top", pin, 1'b1);
    rd(`EBTWU_OFF_COUNT, 8'h00);
    wr(`EBTWU_OFF_CONTROL, 8'h69);
    repeat (3) @(posedge sys_clk);
    wr(`EBTWU_OFF_CONTROL, 8'h68);
    @(posedge sys_clk);
    chk("fast pwm match", pin, 1'b0);
    rd(`EBTWU_OFF_COUNT, 8'h06);
    wr(`EBTWU_OFF_FLAGS, 8'h03);
    wr(`EBTWU_OFF_COUNT, 8'hfe);
    wr(`EBTWU_OFF_CONTROL, 8'h61);
    repeat (255) @(posedge sys_clk);
    wr(`EBTWU_OFF_CONTROL, 8'h60);
    @(posedge sys_clk);
    chk("phase down match", pin, 1'b1);
    chk("overflow flag pin", oflag, 1'b1);
    rd(`EBTWU_OFF_FLAGS, 8'h03);
    rd(`EBTWU_OFF_COUNT, 8'h02);
    wr(`EBTWU_OFF_CONTROL, 8'h61);
    wr(`EBTWU_OFF_CONTROL, 8'h60);
    @(posedge sys_clk);
    chk("phase up match", pin, 1'b0);
    rd(`EBTWU_OFF_COUNT, 8'h05);
    summarize();
  end
endmodule // ebtwu_timer_tb_top
